// >>> network_stop_interlock_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module network_stop_interlock_tb_top;
    import nsi_pkg::*;
    logic clk, rst, stop_enable, start_button, power_fail, nv_save_done, mute, stop_req, start_req;
    logic stopped, track_resume, nv_save_req, bcast;
    logic [3:0] sw_emergency, sw_status;
    logic [5:0] dout_pin;
    logic [15:0] track_held, held_copy;
    logic [31:0] rnd = 32'hbd31;
    nsi_net_in_t net_in;
    nsi_cause_t stop_cause;
    int err_count = 0;
    int num_checks = 0;
    int n;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Assigned switches are 0, 1 and 3
    function automatic logic exp_stop(logic [3:0] sw);
        return |(sw & 4'hb);
    endfunction
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Random gate, output and tracking values
    always @(posedge clk) rnd <= #1 lfsr(rnd);
    nsi_peer u_peer (.clk, .mute, .stop_req, .start_req, .net(net_in));
    nsi_interlock #(.HB_CYCLES(20), .IO_VARIANT(1'b1)) u_dut (.clk, .rst, .stop_enable,
        .sw_assigned(4'hb), .sw_emergency, .start_button, .power_fail, .net_in,
        .net_stop_bcast(bcast), .gate_req(rnd[11:6]), .gate_drive(), .commutate_en(),
        .dout_logical(rnd[5:0]), .dout_pin, .out_relay_on(), .track_live(rnd[31:16]),
        .track_nv(16'h5a5a), .track_nv_valid(1'b1), .track_held, .track_resume,
        .nv_save_req, .nv_save_data(), .nv_save_done, .stopped, .stop_cause, .sw_status);
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Bounded wait; a hang ends the run
    task automatic wait_stop(logic v);
        for (n = 0; n < 300 && stopped !== v; n++) @(posedge clk) #1;
        if (n == 300) begin
            err_count++;
            complete_run();
        end
        chk("stopped", 16'(v), 16'(stopped));
    endtask
    // One-cycle supervisor request, returns just after the taking edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clk) #1 s = 1'b0;
        @(posedge clk) #1;
    endtask
    initial begin
        {rst, stop_enable, start_button, power_fail, nv_save_done, mute, stop_req, start_req} = 8'hc0;
        sw_emergency = 4'h0;
        repeat (6) @(posedge clk) #1;
        rst = 1'b0;
        repeat (4) @(posedge clk) #1;
        chk("pwrup", 16'h1, 16'(stop_cause));
        chk("held", 16'h5a5a, track_held);
        pulse(start_req);
        chk("resume", 16'h1, 16'({stopped, track_resume}));
        repeat (30) @(posedge clk) #1;
        chk("beats", 16'h0, 16'(stopped));
        sw_emergency = 4'h9;
        wait_stop(1'b1);
        sw_emergency = 4'h8;
        repeat (4) @(posedge clk) #1;
        pulse(start_req);
        chk("refused", 16'(exp_stop(sw_emergency)), 16'(stopped));
        sw_emergency = 4'h4;
        repeat (10) @(posedge clk) #1;
        chk("latched", 16'h1, 16'(stopped));
        chk("swstat", 16'h4, 16'(sw_status));
        start_button = 1'b1;
        wait_stop(1'b0);
        start_button = 1'b0;
        pulse(stop_req);
        chk("net", 16'h3, 16'({stopped, stop_cause.net}));
        held_copy = track_held;
        repeat (10) @(posedge clk) #1;
        chk("hold", held_copy, track_held);
        chk("relay", 16'h0, 16'(dout_pin[3:0]));
        pulse(start_req);
        mute = 1'b1;
        wait_stop(1'b1);
        chk("hb", 16'h1, 16'(stop_cause.hb));
        chk("bcast", 16'h1, 16'(bcast));
        mute = 1'b0;
        pulse(start_req);
        power_fail = 1'b1;
        for (n = 0; n < 20 && nv_save_req !== 1'b1; n++) @(posedge clk) #1;
        if (n == 20) begin
            err_count++;
            complete_run();
        end
        repeat (3) @(posedge clk) #1;
        chk("save", 16'h1, 16'(nv_save_req));
        nv_save_done = 1'b1;
        @(posedge clk) #1 nv_save_done = 1'b0;
        power_fail = 1'b0;
        wait_stop(1'b1);
        rst = 1'b1;
        stop_enable = 1'b0;
        repeat (6) @(posedge clk) #1;
        rst = 1'b0;
        wait_stop(1'b0);
        pulse(stop_req);
        chk("ignored", 16'h0, 16'(stopped));
        complete_run();
    end
endmodule
bind nsi_interlock nsi_chk #(.NUM_GATES(NUM_GATES), .TRACK_W(TRACK_W), .HB_CYCLES(HB_CYCLES)) u_chk (
    .clk, .rst, .stop_enable, .start_button, .power_fail, .net_in, .gate_req, .gate_drive,
    .commutate_en, .dout_pin, .out_relay_on, .track_held, .nv_save_data, .nv_save_req,
    .track_resume, .stopped);
`default_nettype wire

// >>> nsi_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nsi_chk #(
    parameter int NUM_GATES = 6,
    parameter int TRACK_W = 16,
    parameter int HB_CYCLES = 20
) (
    // Clock, reset and inputs
    input wire logic clk,
    input wire logic rst,
    input wire logic stop_enable,
    input wire logic start_button,
    input wire logic power_fail,
    input wire nsi_pkg::nsi_net_in_t net_in,
    input wire logic [NUM_GATES-1:0] gate_req,
    // Outputs
    input wire logic [NUM_GATES-1:0] gate_drive,
    input wire logic commutate_en,
    input wire logic [5:0] dout_pin,
    input wire logic out_relay_on,
    input wire logic [TRACK_W-1:0] track_held,
    input wire logic [TRACK_W-1:0] nv_save_data,
    input wire logic nv_save_req,
    input wire logic track_resume,
    input wire logic stopped
);
    import nsi_pkg::*;
    int gap;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since the left beat while running; the gap reaches at most HB_CYCLES, four cycles under the bound
    always_ff @(posedge clk or posedge rst) begin
        if (rst || stopped || net_in.hb_left || !stop_enable) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
    property p_take; net_in.stop_cmd && stop_enable && !stopped |=> stopped && gate_drive == '0;
    endproperty
    a_take: assert property (p_take) else $error("stop not taken");
    property p_order; $rose(stopped) |-> gate_drive == '0 ##1 !commutate_en; endproperty
    a_order: assert property (p_order) else $error("gate off order");
    property p_hold;
        $fell(stopped) |-> !stop_enable || $past(net_in.start_cmd) || $past(start_button, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("run without start");
    property p_relay; stopped && $past(stopped) |-> dout_pin[3:0] == '0 && !out_relay_on;
    endproperty
    a_relay: assert property (p_relay) else $error("relay outputs live");
    property p_follow; !stopped && !$past(stopped) |-> gate_drive == $past(gate_req); endproperty
    a_follow: assert property (p_follow) else $error("gates not following");
    property p_hb; gap <= HB_CYCLES + 4; endproperty
    a_hb: assert property (p_hb) else $error("heartbeat loss missed");
    property p_save;
        $rose(power_fail) && stop_enable |-> ##[2:6] nv_save_req && nv_save_data == track_held;
    endproperty
    a_save: assert property (p_save) else $error("no state save");
    property p_resume; $fell(stopped) && stop_enable |-> track_resume; endproperty
    a_resume: assert property (p_resume) else $error("no resume");
endmodule
`default_nettype wire

// >>> nsi_interlock.sv
// Notes on behaviour
// (RULE_01) No start generated or accepted while any stop switch is in emergency position; the code blocks a start only for switches set in sw_assigned.
// (RULE_02) Returning a switch to normal never restarts nor creates a start command.
// (RULE_03) All assigned switches must be normal before any start is issued or honoured.
// (RULE_04) Stops from network supervisor and local switches are both accepted.
// (RULE_05) I/O variant: stop drops the relay powering four of six outputs.
// (RULE_06) Relay-fed outputs stay unpowered while stopped, whatever the logical value.
// (RULE_07) Motor variant: gates go non-conducting first, then commutation is suspended.
// (RULE_08) While stopped, pre-stop state is held and status stays readable.
// (RULE_09) On falling supply with stop enabled, state is saved to non-volatile memory.
// (RULE_10) After power returns, stop group stays stopped until a start command.
// (RULE_11) With stop disabled, run immediately after power-up without any start.
// (RULE_12) A received stop holds motion and outputs stopped until a separate start.
// (RULE_13) Missing neighbour heartbeat for 200 ms disables gates and broadcasts stop.
// (RULE_14) On start, resume the transfer and tracking held at stop time.
`timescale 1ns/1ps
`default_nettype none
`include "nsi_map.svh"

module nsi_interlock #(
    parameter int NUM_SW = `NSI_NUM_SW,
    parameter int NUM_GATES = `NSI_NUM_GATES,
    parameter int TRACK_W = 16,
    parameter int HB_CYCLES = `NSI_HB_CYCLES,
    parameter bit IO_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration straps
    input wire logic stop_enable,
    input wire logic [NUM_SW-1:0] sw_assigned,
    // Maintained stop switches (high = emergency) and start buttons, asynchronous pins
    input wire logic [NUM_SW-1:0] sw_emergency,
    input wire logic start_button,
    // Supply monitor pin, high while supply is falling
    input wire logic power_fail,
    // Network side, same clock domain
    input wire nsi_pkg::nsi_net_in_t net_in,
    output logic net_stop_bcast,
    // Motor stage
    input wire logic [NUM_GATES-1:0] gate_req,
    output logic [NUM_GATES-1:0] gate_drive,
    output logic commutate_en,
    // Output module stage
    input wire logic [`NSI_NUM_DOUT-1:0] dout_logical,
    output logic [`NSI_NUM_DOUT-1:0] dout_pin,
    output logic out_relay_on,
    // Tracking state from the transfer logic, and the copy held or restored
    input wire logic [TRACK_W-1:0] track_live,
    input wire logic [TRACK_W-1:0] track_nv,
    input wire logic track_nv_valid,
    output logic [TRACK_W-1:0] track_held,
    output logic track_resume,
    // Non-volatile save port
    output logic nv_save_req,
    output logic [TRACK_W-1:0] nv_save_data,
    input wire logic nv_save_done,
    // Status visible over the network
    output logic stopped,
    output nsi_pkg::nsi_cause_t stop_cause,
    output logic [NUM_SW-1:0] sw_status
);
    import nsi_pkg::*;

    typedef struct packed {
        logic [NUM_SW-1:0] sw_m;
        logic [NUM_SW-1:0] sw_s;
        logic btn_m;
        logic btn_s;
        logic btn_d;
        logic pf_m;
        logic pf_s;
        logic init_done;
        logic [`NSI_HB_CNT_W-1:0] hb_l_cnt;
        logic [`NSI_HB_CNT_W-1:0] hb_r_cnt;
        nsi_state_t state;
        nsi_cause_t cause;
        logic saved;
        logic [TRACK_W-1:0] held;
        logic resume;
        logic bcast;
        logic [NUM_GATES-1:0] gates;
        logic comm;
        logic relay;
        logic [`NSI_NUM_DOUT-1:0] dout;
        logic nv_req;
        logic stop_o;
    } nsi_st_t;

    localparam logic [`NSI_HB_CNT_W-1:0] HB_LIMIT = `NSI_HB_CNT_W'(HB_CYCLES - 1);

    nsi_st_t st_reg;
    nsi_st_t st_next;
    logic any_emerg;
    logic start_ok;
    logic stop_now;
    logic hb_lost;

    // Qualify a start: never while an assigned switch is in emergency position
    function automatic logic all_normal(input logic [NUM_SW-1:0] sw, input logic [NUM_SW-1:0] asg);
        all_normal = ~|(sw & asg);
    endfunction

    always_comb begin
        st_next = st_reg;
        // Pins pass two flops before use
        st_next.sw_m = sw_emergency;
        st_next.sw_s = st_reg.sw_m;
        st_next.btn_m = start_button;
        st_next.btn_s = st_reg.btn_m;
        st_next.btn_d = st_reg.btn_s;
        st_next.pf_m = power_fail;
        st_next.pf_s = st_reg.pf_m;
        st_next.resume = 1'b0;
        st_next.bcast = 1'b0;

        any_emerg = ~all_normal(st_reg.sw_s, sw_assigned);
        // Start is an edge of the button or a network pulse, gated by every assigned switch
        start_ok = (net_in.start_cmd | (st_reg.btn_s & ~st_reg.btn_d))
                   & ~any_emerg; // [RULE_01] [RULE_03]

        // Heartbeat watchdogs, one per neighbour ring
        hb_lost = 1'b0;
        if (net_in.hb_left || st_reg.state != NSI_RUN) begin
            st_next.hb_l_cnt = '0;
        end else if (st_reg.hb_l_cnt == HB_LIMIT) begin
            hb_lost = 1'b1; // [RULE_13]
        end else begin
            st_next.hb_l_cnt = st_reg.hb_l_cnt + 1'b1;
        end
        if (net_in.hb_right || st_reg.state != NSI_RUN) begin
            st_next.hb_r_cnt = '0;
        end else if (st_reg.hb_r_cnt == HB_LIMIT) begin
            hb_lost = 1'b1; // [RULE_13]
        end else begin
            st_next.hb_r_cnt = st_reg.hb_r_cnt + 1'b1;
        end
        hb_lost = hb_lost & stop_enable;

        // Local switch and supervisor stop both accepted
        stop_now = stop_enable & (any_emerg | net_in.stop_cmd | hb_lost); // [RULE_04]

        // Power-up: disabled runs at once, enabled waits for a start
        if (!st_reg.init_done) begin
            st_next.init_done = 1'b1;
            if (stop_enable) begin
                st_next.state = NSI_GATE_OFF; // [RULE_10]
                st_next.cause.pwr = 1'b1;
                if (track_nv_valid) begin
                    st_next.held = track_nv;
                end
            end else begin
                st_next.state = NSI_RUN; // [RULE_11]
            end
        end else begin
            unique case (st_reg.state)
                NSI_RUN: begin
                    if (stop_enable && st_reg.pf_s) begin
                        st_next.held = track_live;
                        st_next.state = NSI_SAVE;
                    end else if (stop_now) begin
                        st_next.held = track_live; // [RULE_08]
                        st_next.cause.sw = any_emerg;
                        st_next.cause.net = net_in.stop_cmd;
                        st_next.cause.hb = hb_lost;
                        st_next.bcast = hb_lost; // [RULE_13]
                        st_next.state = NSI_GATE_OFF;
                    end
                end
                NSI_GATE_OFF: begin
                    // Gates already off this cycle; sequencer halts next
                    st_next.state = NSI_STOPPED; // [RULE_07]
                end
                NSI_STOPPED: begin
                    if (stop_enable && st_reg.pf_s && !st_reg.saved) begin
                        st_next.state = NSI_SAVE;
                    end else if (start_ok && !net_in.stop_cmd) begin
                        // Only an explicit start returns to run; switch release alone does not
                        st_next.state = NSI_RUN; // [RULE_02] [RULE_12]
                        st_next.resume = 1'b1; // [RULE_14]
                        st_next.cause = '0;
                        st_next.saved = 1'b0;
                    end
                end
                NSI_SAVE: begin
                    if (nv_save_done) begin
                        st_next.saved = 1'b1; // [RULE_09]
                        st_next.state = NSI_STOPPED;
                    end
                end
            endcase
        end
        st_next.nv_req = (st_next.state == NSI_SAVE);
        // Status flag registered so the port comes straight from a flop
        st_next.stop_o = (st_next.state != NSI_RUN);

        // Output stage: gates forced off and relay dropped outside run
        if (st_next.state == NSI_RUN) begin
            st_next.gates = gate_req;
            st_next.comm = 1'b1;
            st_next.relay = 1'b1;
        end else begin
            st_next.gates = '0; // [RULE_07]
            st_next.relay = 1'b0; // [RULE_05]
            st_next.comm = (st_reg.state == NSI_RUN) ? 1'b1 : 1'b0; // [RULE_07]
        end
        if (!IO_VARIANT) begin
            st_next.relay = 1'b0;
        end
        st_next.dout = dout_logical;
        for (int i = 0; i < `NSI_NUM_RELAY_DOUT; i++) begin
            st_next.dout[i] = dout_logical[i] & st_next.relay; // [RULE_06]
        end
    end

    // Single state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.state <= NSI_GATE_OFF;
            st_reg.stop_o <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign net_stop_bcast = st_reg.bcast;
    assign gate_drive = st_reg.gates;
    assign commutate_en = st_reg.comm;
    assign dout_pin = st_reg.dout;
    assign out_relay_on = st_reg.relay;
    assign track_held = st_reg.held;
    assign track_resume = st_reg.resume;
    assign nv_save_req = st_reg.nv_req;
    assign nv_save_data = st_reg.held;
    assign stopped = st_reg.stop_o;
    assign stop_cause = st_reg.cause;
    assign sw_status = st_reg.sw_s; // [RULE_08]
endmodule
`default_nettype wire

// >>> nsi_map.svh
`ifndef NSI_MAP_SVH
`define NSI_MAP_SVH

// Clock rate and heartbeat window
`define NSI_CLK_MHZ 250
`define NSI_HB_TIMEOUT_MS 200
`define NSI_HB_CYCLES (`NSI_HB_TIMEOUT_MS * 1000 * `NSI_CLK_MHZ)

// Counts and widths
`define NSI_NUM_SW 4
`define NSI_NUM_DOUT 6
`define NSI_NUM_RELAY_DOUT 4
`define NSI_NUM_GATES 6
`define NSI_HB_CNT_W 26

`endif

// >>> nsi_peer.sv
`timescale 1ns/1ps
`default_nettype none
module nsi_peer (
    // Clock and test controls
    input wire logic clk,
    input wire logic mute,
    input wire logic stop_req,
    input wire logic start_req,
    // Group traffic into the block
    output var nsi_pkg::nsi_net_in_t net
);
    import nsi_pkg::*;
    logic [2:0] cnt = 3'h0;
    initial net = '0;
    // Neighbours beat every 8 cycles, skewed so they never coincide; mute models a lost peer
    always @(posedge clk) begin
        cnt <= cnt + 3'h1;
        net.hb_left <= #1 !mute && cnt == 3'h0;
        net.hb_right <= #1 !mute && cnt == 3'h4;
        net.stop_cmd <= #1 stop_req; // One operator action gives one pulse
        net.start_cmd <= #1 start_req;
    end
endmodule
`default_nettype wire

// >>> nsi_pkg.sv
`include "nsi_map.svh"

package nsi_pkg;
    // Reasons the stop latched, kept for diagnostics
    typedef struct packed {
        logic sw;
        logic net;
        logic hb;
        logic pwr;
    } nsi_cause_t;

    // Network side inputs, one-cycle pulses from the same clock domain
    typedef struct packed {
        logic stop_cmd;
        logic start_cmd;
        logic hb_left;
        logic hb_right;
    } nsi_net_in_t;

    // Interlock sequencer states
    typedef enum logic [3:0] {
        NSI_RUN = 4'b0001,
        NSI_GATE_OFF = 4'b0010,
        NSI_STOPPED = 4'b0100,
        NSI_SAVE = 4'b1000
    } nsi_state_t;
endpackage
